// ===== rtl/ptp_frame_timestamp_unit.sv
// Four-MAC frame timestamp unit with an AHB-Lite register slave.
//
// How it works
// R1: User logic supplies a 64-bit counter, nanoseconds low wrapping at 10^9, seconds high.
// R2: The counter input must be synchronous to the halved reference clock.
// R3: User logic should run the counter at 500MHz stepping by two.
// R4: Egress timestamp equals the counter when the packet enters the MAC.
// R5: A 4-bit frame tag from the control vector accompanies the egress timestamp.
// R6: A one-cycle valid pulse qualifies egress timestamp and frame tag.
// R7: User logic supplies a 30-bit peer delay with a valid strobe; it is held.
// R8: Every per-MAC signal is four times as wide, one slice per MAC.
// R9: All per-MAC signals are synchronous to the halved clock.
// R10: A received packet samples the counter as its ingress timestamp.
// R11: Ingress timestamp bits 29:0 appear together with the start-of-packet pulse.
// R12: For event frames user logic sets the frame flag, control vector and stamp field.
// R13: User logic loads the stamp field from the ingress stamp or counter bits.
// R14: Flagged frames store the low 32 egress bits in a readable capture register.
// R15: Each new capture sets the ready flag.
// R16: Software flags only frames needing stamps, polls ready, then reads the capture.
// R17: Unflagged frames leave the capture register and ready flag untouched.
// R18: The fabric stamp field is 30 bits while the capture holds 32.
// R19: The frame flag is tx flags bit 17; the control vector counts only then.
// R20: Control vector bits 3:0 are an opaque tag returned unchanged.
// R21: Later captures overwrite; ready stays set until software reads the capture.
module ptp_frame_timestamp_unit (
	// Clock and reset; the clock is the halved reference clock.
	input  wire logic                                                   ref_clk_in,
	input  wire logic                                                   rstn_in,
	// AHB-Lite slave.
	input  wire logic                                                   hsel_in,
	input  wire logic [31:0]                                            haddr_in,
	input  wire logic [1:0]                                             htrans_in,
	input  wire logic                                                   hwrite_in,
	input  wire logic [2:0]                                             hsize_in,
	input  wire logic [31:0]                                            hwdata_in,
	input  wire logic                                                   hready_in,
	output logic      [31:0]                                            hrdata_out,
	output logic                                                        hreadyout_out,
	output logic                                                        hresp_out,
	// Shared time counter.
	input  wire logic [ptp_ts_pkg::TIME_W-1:0]                          time_count_in,
	// Transmit side, one slice per MAC.
	input  wire logic [ptp_ts_pkg::MAC_COUNT-1:0]                       tx_start_in,
	input  wire logic [ptp_ts_pkg::MAC_COUNT*ptp_ts_pkg::TX_FLAGS_W-1:0] tx_flags_in,
	// Receive side, one slice per MAC.
	input  wire logic [ptp_ts_pkg::MAC_COUNT-1:0]                       rx_start_in,
	// Peer delay, one slice per MAC.
	input  wire logic [ptp_ts_pkg::MAC_COUNT*ptp_ts_pkg::PEER_DELAY_W-1:0] peer_delay_in,
	input  wire logic [ptp_ts_pkg::MAC_COUNT-1:0]                       peer_delay_valid_in,
	// Egress results, one slice per MAC.
	output logic      [ptp_ts_pkg::MAC_COUNT*ptp_ts_pkg::TIME_W-1:0]    egress_time_out,
	output logic      [ptp_ts_pkg::MAC_COUNT*ptp_ts_pkg::TAG_W-1:0]     egress_frame_tag_out,
	output logic      [ptp_ts_pkg::MAC_COUNT-1:0]                       egress_time_valid_out,
	// Ingress results, one slice per MAC.
	output logic      [ptp_ts_pkg::MAC_COUNT*ptp_ts_pkg::RX_TIME_W-1:0] rx_time_out,
	output logic      [ptp_ts_pkg::MAC_COUNT-1:0]                       packet_start_pulse_out
);

	localparam int MAC_N = ptp_ts_pkg::MAC_COUNT;

	typedef struct packed {
		logic [31:0]      hrdata;
		logic             hreadyout;
		logic             hresp;
		logic             wr_pend;
		logic [1:0]       wr_mac;
		logic [1:0]       wr_reg;
		logic [MAC_N-1:0] enable;
	} bus_state_s;

	bus_state_s s;
	bus_state_s next_s;

	logic [MAC_N-1:0]                              capture_read;
	logic [MAC_N*ptp_ts_pkg::NS_W-1:0]             captured_all;
	logic [MAC_N-1:0]                              ready_all;
	logic [MAC_N*ptp_ts_pkg::PEER_DELAY_W-1:0]     peer_all;
	logic                                          accept;
	logic                                          mapped;
	logic [1:0]                                    addr_mac;
	logic [1:0]                                    addr_reg;

	// Address phase decode; anything above the four windows reads zero and ignores writes.
	assign accept   = hsel_in & hready_in & htrans_in[ptp_ts_pkg::HTRANS_ACTIVE_BIT];
	assign mapped   = (haddr_in < (ptp_ts_pkg::MAC_STRIDE * MAC_N));
	assign addr_mac = haddr_in[5:4];
	assign addr_reg = haddr_in[3:2];

	// Bus and control next state.  Read data is prepared in the address phase so the
	// slave never inserts wait states.
	always_comb begin
		next_s           = s;
		next_s.hreadyout = 1'b1;
		next_s.hresp     = 1'b0;
		next_s.wr_pend   = accept & hwrite_in & mapped;
		next_s.wr_mac    = addr_mac;
		next_s.wr_reg    = addr_reg;
		if (s.wr_pend && (s.wr_reg == ptp_ts_pkg::REG_CONTROL)) begin
			next_s.enable[s.wr_mac] = hwdata_in[ptp_ts_pkg::ENABLE_BIT];
		end
		next_s.hrdata = ptp_ts_pkg::RDATA_RESET;
		if (accept && !hwrite_in && mapped) begin
			unique case (addr_reg)
				ptp_ts_pkg::REG_CAPTURE: begin
					next_s.hrdata = captured_all[addr_mac*ptp_ts_pkg::NS_W +: ptp_ts_pkg::NS_W]; // R14
				end
				ptp_ts_pkg::REG_STATUS: begin
					next_s.hrdata[ptp_ts_pkg::READY_FLAG_BIT] = ready_all[addr_mac]; // R15
				end
				ptp_ts_pkg::REG_PEER_DELAY: begin
					next_s.hrdata[ptp_ts_pkg::PEER_DELAY_W-1:0] =
						peer_all[addr_mac*ptp_ts_pkg::PEER_DELAY_W +: ptp_ts_pkg::PEER_DELAY_W];
				end
				ptp_ts_pkg::REG_CONTROL: begin
					next_s.hrdata[ptp_ts_pkg::ENABLE_BIT] = s.enable[addr_mac];
				end
			endcase
		end
	end

	// Bus state register.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			s           <= '0;
			s.hreadyout <= 1'b1;
			s.enable    <= ptp_ts_pkg::CONTROL_ENABLE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign hrdata_out    = s.hrdata;
	assign hreadyout_out = s.hreadyout;
	assign hresp_out     = s.hresp;

	// One slice per MAC; a read of a capture register clears only that MAC's flag.
	genvar gi;
	generate
		for (gi = 0; gi < MAC_N; gi++) begin : g_mac
			assign capture_read[gi] = accept & ~hwrite_in & mapped &
				(addr_mac == 2'(gi)) & (addr_reg == ptp_ts_pkg::REG_CAPTURE); // R21
			mac_ts_slice u_slice ( // R8 R9
				.ref_clk_in                 (ref_clk_in),
				.rstn_in                    (rstn_in),
				.time_count_in              (time_count_in),
				.tx_start_in                (tx_start_in[gi]),
				.tx_flags_in                (tx_flags_in[gi*ptp_ts_pkg::TX_FLAGS_W +: ptp_ts_pkg::TX_FLAGS_W]),
				.rx_start_in                (rx_start_in[gi]),
				.peer_delay_in              (peer_delay_in[gi*ptp_ts_pkg::PEER_DELAY_W +: ptp_ts_pkg::PEER_DELAY_W]),
				.peer_delay_valid_in        (peer_delay_valid_in[gi]),
				.enable_in                  (s.enable[gi]),
				.capture_read_in            (capture_read[gi]),
				.egress_time_out            (egress_time_out[gi*ptp_ts_pkg::TIME_W +: ptp_ts_pkg::TIME_W]),
				.egress_frame_tag_out       (egress_frame_tag_out[gi*ptp_ts_pkg::TAG_W +: ptp_ts_pkg::TAG_W]),
				.egress_time_valid_out      (egress_time_valid_out[gi]),
				.rx_time_out                (rx_time_out[gi*ptp_ts_pkg::RX_TIME_W +: ptp_ts_pkg::RX_TIME_W]),
				.packet_start_pulse_out     (packet_start_pulse_out[gi]),
				.captured_egress_time_out   (captured_all[gi*ptp_ts_pkg::NS_W +: ptp_ts_pkg::NS_W]),
				.egress_time_ready_flag_out (ready_all[gi]),
				.peer_delay_out             (peer_all[gi*ptp_ts_pkg::PEER_DELAY_W +: ptp_ts_pkg::PEER_DELAY_W])
			);
		end
	endgenerate

endmodule : ptp_frame_timestamp_unit

// ===== rtl/ptp_ts_pkg.sv
// Shared constants for the frame timestamp unit and its per-MAC slice.
package ptp_ts_pkg;

	// Datapath widths.
	localparam int MAC_COUNT      = 4;
	localparam int TIME_W         = 64;
	localparam int NS_W           = 32;
	localparam int RX_TIME_W      = 30;
	localparam int PEER_DELAY_W   = 30;
	localparam int TAG_W          = 4;
	localparam int TX_FLAGS_W     = 18;
	localparam int FRAME_FLAG_BIT = 17;
	localparam int TAG_LSB        = 0;

	// Register map: one 16-byte window per MAC, registers at word offsets inside it.
	localparam logic [31:0] MAC_STRIDE      = 32'h0000_0010;
	localparam logic [1:0]  REG_CAPTURE     = 2'h0;
	localparam logic [1:0]  REG_STATUS      = 2'h1;
	localparam logic [1:0]  REG_PEER_DELAY  = 2'h2;
	localparam logic [1:0]  REG_CONTROL     = 2'h3;
	localparam int          READY_FLAG_BIT  = 0;
	localparam int          ENABLE_BIT      = 0;

	// Reset values.
	localparam logic [MAC_COUNT-1:0] CONTROL_ENABLE_RESET = 4'hF;
	localparam logic [31:0]          RDATA_RESET          = 32'h0000_0000;

	// AHB-Lite transfer type bit that marks NONSEQ or SEQ.
	localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : ptp_ts_pkg

// ===== rtl/mac_ts_slice.sv
// Timestamp logic for one MAC: egress stamp, ingress stamp and the software capture register.
module mac_ts_slice (
	// Clock and reset.
	input  wire logic                                  ref_clk_in,
	input  wire logic                                  rstn_in,
	// Shared time counter.
	input  wire logic [ptp_ts_pkg::TIME_W-1:0]         time_count_in,
	// Transmit side.
	input  wire logic                                  tx_start_in,
	input  wire logic [ptp_ts_pkg::TX_FLAGS_W-1:0]     tx_flags_in,
	// Receive side.
	input  wire logic                                  rx_start_in,
	// Peer delay from user logic.
	input  wire logic [ptp_ts_pkg::PEER_DELAY_W-1:0]   peer_delay_in,
	input  wire logic                                  peer_delay_valid_in,
	// Software control.
	input  wire logic                                  enable_in,
	input  wire logic                                  capture_read_in,
	// Egress results.
	output logic      [ptp_ts_pkg::TIME_W-1:0]         egress_time_out,
	output logic      [ptp_ts_pkg::TAG_W-1:0]          egress_frame_tag_out,
	output logic                                       egress_time_valid_out,
	// Ingress results.
	output logic      [ptp_ts_pkg::RX_TIME_W-1:0]      rx_time_out,
	output logic                                       packet_start_pulse_out,
	// Software-visible state.
	output logic      [ptp_ts_pkg::NS_W-1:0]           captured_egress_time_out,
	output logic                                       egress_time_ready_flag_out,
	output logic      [ptp_ts_pkg::PEER_DELAY_W-1:0]   peer_delay_out
);

	typedef struct packed {
		logic [ptp_ts_pkg::TIME_W-1:0]       egress_time;
		logic [ptp_ts_pkg::TAG_W-1:0]        tag;
		logic                                valid;
		logic [ptp_ts_pkg::RX_TIME_W-1:0]    rx_time;
		logic                                rx_start;
		logic [ptp_ts_pkg::NS_W-1:0]         captured;
		logic                                ready;
		logic [ptp_ts_pkg::PEER_DELAY_W-1:0] peer_delay;
	} slice_state_s;

	slice_state_s s;
	slice_state_s next_s;
	logic         flagged;

	// A frame is stamped only when its frame flag is set and the slice is enabled.
	assign flagged = tx_start_in & tx_flags_in[ptp_ts_pkg::FRAME_FLAG_BIT] & enable_in; // R19

	// Next-state logic for the whole slice.
	always_comb begin
		next_s       = s;
		next_s.valid = 1'b0; // R6
		if (flagged) begin
			next_s.egress_time = time_count_in; // R4
			next_s.tag         = tx_flags_in[ptp_ts_pkg::TAG_LSB +: ptp_ts_pkg::TAG_W]; // R5 R20
			next_s.valid       = 1'b1; // R6
			next_s.captured    = time_count_in[ptp_ts_pkg::NS_W-1:0]; // R14 R18 R21
		end
		// The read clears the flag first so that a capture in the same cycle still sets it.
		if (capture_read_in) begin
			next_s.ready = 1'b0; // R21
		end
		if (flagged) begin
			next_s.ready = 1'b1; // R15 R17
		end
		// Ingress stamp travels with the start pulse; both leave one cycle later together.
		next_s.rx_start = rx_start_in; // R11
		if (rx_start_in) begin
			next_s.rx_time = time_count_in[ptp_ts_pkg::RX_TIME_W-1:0]; // R10 R11
		end
		if (peer_delay_valid_in) begin
			next_s.peer_delay = peer_delay_in; // R7
		end
	end

	// State register, synchronous active-low reset.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops.
	assign egress_time_out            = s.egress_time;
	assign egress_frame_tag_out       = s.tag;
	assign egress_time_valid_out      = s.valid;
	assign rx_time_out                = s.rx_time;
	assign packet_start_pulse_out     = s.rx_start;
	assign captured_egress_time_out   = s.captured;
	assign egress_time_ready_flag_out = s.ready;
	assign peer_delay_out             = s.peer_delay;

endmodule : mac_ts_slice

// ===== sim/fabric_time_source.sv
// User-fabric time counter model: seconds in the upper word, wrapping nanoseconds in the lower.
module fabric_time_source (
	// Clock and reset.
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	// Time counter.
	output logic      [63:0] time_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Starts just below a second boundary so the nanosecond wrap is crossed early in the run.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			time_count_out <= {32'h0000_0000, 32'h3B9A_C9F6};
		end else if (time_count_out[31:0] >= 32'h3B9A_C9FE) begin
			time_count_out <= {time_count_out[63:32] + 32'h0000_0001, time_count_out[31:0] - 32'h3B9A_C9FE};
		end else begin
			time_count_out <= time_count_out + 64'h0000_0000_0000_0002;
		end
	end
endmodule : fabric_time_source

// ===== sim/ptp_frame_timestamp_unit_checker.sv
// Port-level timing checks for the frame timestamp unit.
module ptp_frame_timestamp_unit_checker (
	// Clock, reset and bus.
	input wire logic         ref_clk_in,
	input wire logic         rstn_in,
	input wire logic         hsel_in,
	input wire logic [31:0]  haddr_in,
	input wire logic [31:0]  hwdata_in,
	input wire logic [1:0]   htrans_in,
	input wire logic         hwrite_in,
	input wire logic         hready_in,
	input wire logic [31:0]  hrdata_out,
	input wire logic         hreadyout_out,
	input wire logic         hresp_out,
	// Timestamp traffic.
	input wire logic [63:0]  time_count_in,
	input wire logic [3:0]   tx_start_in,
	input wire logic [71:0]  tx_flags_in,
	input wire logic [3:0]   rx_start_in,
	input wire logic [255:0] egress_time_out,
	input wire logic [15:0]  egress_frame_tag_out,
	input wire logic [3:0]   egress_time_valid_out,
	input wire logic [119:0] rx_time_out,
	input wire logic [3:0]   packet_start_pulse_out
);
	logic [3:0] flagged;
	logic       rd_phase;
	logic [3:0] en_model;
	logic       wr_ctl;
	logic [1:0] wr_mac;
	// Own copy of the per-MAC enable bits, kept from control writes seen on the bus.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			en_model <= 4'hF;
			wr_ctl   <= 1'b0;
			wr_mac   <= 2'h0;
		end else begin
			wr_ctl <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in < 32'h0000_0040 &&
				haddr_in[3:2] == 2'h3;
			wr_mac <= haddr_in[5:4];
			if (wr_ctl) begin
				en_model[wr_mac] <= hwdata_in[0];
			end
		end
	end
	// Frame flag of each slice, so one compare covers all four MACs.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			flagged[i] = tx_flags_in[i*18+17];
		end
	end
	// Read data phase tracker; outside it read data must be zero.
	always_ff @(posedge ref_clk_in) begin
		rd_phase <= rstn_in && hsel_in && hready_in && htrans_in[1] && !hwrite_in;
	end
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);
	sequence s_flagged0;
		tx_start_in[0] && tx_flags_in[17] && en_model[0];
	endsequence
	sequence s_stamp0;
		egress_time_valid_out[0] && egress_frame_tag_out[3:0] == $past(tx_flags_in[3:0]);
	endsequence
	AST_VALID_CAUSE: assert property (egress_time_valid_out == $past(tx_start_in & flagged & en_model))
		else $error("egress valid not caused by a flagged start");
	AST_STAMP_TIME: assert property (s_flagged0 |=> egress_time_out[63:0] == $past(time_count_in))
		else $error("egress time differs from counter");
	AST_TAG: assert property (s_flagged0 |=> s_stamp0)
		else $error("frame tag not returned");
	AST_HOLD: assert property (!egress_time_valid_out[1] |-> $stable(egress_time_out[127:64]))
		else $error("egress time moved without valid");
	AST_RX_PULSE: assert property (packet_start_pulse_out == $past(rx_start_in))
		else $error("start pulse misplaced");
	AST_RX_TIME: assert property (packet_start_pulse_out[2] |-> rx_time_out[89:60] == $past(time_count_in[29:0]))
		else $error("ingress time wrong");
	AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
		else $error("bus not ready or not okay");
	AST_RDATA_IDLE: assert property (!rd_phase |-> hrdata_out == 32'h0000_0000)
		else $error("read data outside data phase");
endmodule : ptp_frame_timestamp_unit_checker
bind ptp_frame_timestamp_unit ptp_frame_timestamp_unit_checker checker_inst (.ref_clk_in, .rstn_in, .hsel_in,
	.haddr_in, .hwdata_in,
	.htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .time_count_in, .tx_start_in,
	.tx_flags_in, .rx_start_in, .egress_time_out, .egress_frame_tag_out, .egress_time_valid_out, .rx_time_out,
	.packet_start_pulse_out);

// ===== sim/tb_ptp_frame_timestamp_unit.sv
// Self-checking bench for the four-MAC frame timestamp unit.
module tb_ptp_frame_timestamp_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [63:0] time_count;
	logic [3:0] tx_start, rx_start, peer_valid, egress_valid, rx_pulse;
	logic [71:0] tx_flags;
	logic [119:0] peer_delay, rx_time;
	logic [255:0] egress_time;
	logic [15:0] egress_tag;
	int bad_count, n_compared;
	fabric_time_source fabric_time_source_inst (.ref_clk_in(ref_clk), .rstn_in(rstn), .time_count_out(time_count));
	ptp_frame_timestamp_unit ptp_frame_timestamp_unit_inst (.ref_clk_in(ref_clk), .rstn_in(rstn), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
		.time_count_in(time_count), .tx_start_in(tx_start), .tx_flags_in(tx_flags), .rx_start_in(rx_start),
		.peer_delay_in(peer_delay), .peer_delay_valid_in(peer_valid), .egress_time_out(egress_time),
		.egress_frame_tag_out(egress_tag), .egress_time_valid_out(egress_valid), .rx_time_out(rx_time),
		.packet_start_pulse_out(rx_pulse));
	// Prints the verdict and ends the run.
	task automatic close_out;
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// Case inequality so an unknown never passes as a match.
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	function automatic logic [31:0] addr(input int m, input logic [1:0] r);
		return 32'(m) * ptp_ts_pkg::MAC_STRIDE + {28'h000_0000, r, 2'h0};
	endfunction : addr
	// One single transfer; both hready waits are bounded so a stuck slave ends the run.
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge ref_clk) k++; while (hreadyout !== 1'b1 && k < 40);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			close_out();
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		k = 0;
		do @(posedge ref_clk) k++; while (hreadyout !== 1'b1 && k < 40);
		rd = hrdata;
		if (hreadyout !== 1'b1) begin
			bad_count++;
			close_out();
		end
	endtask : ahb
	// Reset values, control read-write and an unmapped access.
	task automatic t_regs;
		logic [31:0] r;
		ahb(1'b0, addr(1, ptp_ts_pkg::REG_STATUS), 32'h0, r);
		check("status reset", 64'h0, r);
		ahb(1'b0, addr(0, ptp_ts_pkg::REG_CONTROL), 32'h0, r);
		check("control reset", 64'h1, r);
		ahb(1'b1, addr(3, ptp_ts_pkg::REG_CONTROL), 32'h0, r);
		ahb(1'b0, addr(3, ptp_ts_pkg::REG_CONTROL), 32'h0, r);
		check("control write", 64'h0, r);
		// A flagged frame on a disabled MAC must leave no trace.
		tx_start[3] <= 1'b1;
		tx_flags[54 +: 18] <= 18'h2_0005;
		@(posedge ref_clk);
		tx_start[3] <= 1'b0;
		#1;
		check("disabled valid", 64'h0, {63'h0, egress_valid[3]});
		@(posedge ref_clk);
		ahb(1'b0, addr(3, ptp_ts_pkg::REG_STATUS), 32'h0, r);
		check("disabled ready", 64'h0, r);
		ahb(1'b1, addr(3, ptp_ts_pkg::REG_CONTROL), 32'h1, r);
		ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, r);
		ahb(1'b0, 32'h0000_0040, 32'h0, r);
		check("unmapped read", 64'h0, r);
	endtask : t_regs
	// One frame on MAC m; the stamp is the counter at the edge that takes the start.
	task automatic send(input int m, input logic flag, input logic [3:0] tag, output logic [63:0] t);
		tx_start[m] <= 1'b1;
		tx_flags[m*18 +: 18] <= {flag, 13'h0000, tag};
		@(posedge ref_clk);
		t = time_count;
		tx_start[m] <= 1'b0;
		#1;
		check("egress valid", {63'h0, flag}, {63'h0, egress_valid[m]});
		if (flag) begin
			check("egress time", t, egress_time[m*64 +: 64]);
			check("egress tag", {60'h0, tag}, {60'h0, egress_tag[m*4 +: 4]});
		end
		@(posedge ref_clk);
		#1;
		check("valid width", 64'h0, {63'h0, egress_valid[m]});
		@(posedge ref_clk);
	endtask : send
	// Capture, unflagged frame, overwrite, read-only write and read-clear on one MAC.
	task automatic t_capture(input int m);
		logic [63:0] a, b;
		logic [31:0] r;
		send(m, 1'b1, 4'(m + 9), a);
		send(m, 1'b0, 4'h3, b);
		ahb(1'b0, addr(m, ptp_ts_pkg::REG_STATUS), 32'h0, r);
		check("ready flag", 64'h1, r);
		ahb(1'b0, addr(m, ptp_ts_pkg::REG_CAPTURE), 32'h0, r);
		check("capture", {32'h0, a[31:0]}, r);
		send(m, 1'b1, 4'h6, a);
		send(m, 1'b1, 4'hF, b);
		ahb(1'b1, addr(m, ptp_ts_pkg::REG_CAPTURE), 32'h1234_5678, r);
		ahb(1'b0, addr(m, ptp_ts_pkg::REG_CAPTURE), 32'h0, r);
		check("overwrite", {32'h0, b[31:0]}, r);
		ahb(1'b0, addr(m, ptp_ts_pkg::REG_STATUS), 32'h0, r);
		check("ready cleared", 64'h0, r);
		send(m, 1'b0, 4'h5, a);
		ahb(1'b0, addr(m, ptp_ts_pkg::REG_STATUS), 32'h0, r);
		check("ready after unflagged", 64'h0, r);
		ahb(1'b0, addr(m, ptp_ts_pkg::REG_CAPTURE), 32'h0, r);
		check("capture after unflagged", {32'h0, b[31:0]}, r);
	endtask : t_capture
	// Ingress stamp and peer delay on every MAC.
	task automatic t_rx_peer;
		logic [63:0] t;
		logic [31:0] r;
		for (int m = 0; m < 4; m++) begin
			rx_start[m] <= 1'b1;
			peer_delay[m*30 +: 30] <= 30'h2AAA_5550 + 30'(m);
			peer_valid[m] <= 1'b1;
			@(posedge ref_clk);
			t = time_count;
			rx_start[m] <= 1'b0;
			peer_valid[m] <= 1'b0;
			#1;
			check("rx pulse", 64'h1, {63'h0, rx_pulse[m]});
			check("rx time", {34'h0, t[29:0]}, {34'h0, rx_time[m*30 +: 30]});
			@(posedge ref_clk);
			ahb(1'b0, addr(m, ptp_ts_pkg::REG_PEER_DELAY), 32'h0, r);
			check("peer delay", 64'h2AAA_5550 + 64'(m), r);
		end
	endtask : t_rx_peer
	// Clock at 40 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Reset for 12 cycles, then the scenarios in turn.
	initial begin
		{rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{tx_start, rx_start, peer_valid, tx_flags, peer_delay} = '0;
		bad_count = 0;
		n_compared = 0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		for (int m = 0; m < 4; m++) begin
			t_capture(m);
		end
		t_rx_peer();
		close_out();
	end
endmodule : tb_ptp_frame_timestamp_unit
